/* rtl/analog_blocks_regs.svh */
/*
  Constants for the analog compare and scale blocks.
  Assumes inclusion by bare name from rtl files.
*/
`ifndef ANALOG_BLOCKS_REGS_SVH
`define ANALOG_BLOCKS_REGS_SVH
`define RAW_MAX 16'sh03E8
`define GAIN_MAX 16'sh03E8
`define OFFSET_MAX 16'sh2710
`define THRESH_MAX 16'sh4E20
`define OUT_MAX 32'sh00007FFF
`define OUT_MIN 32'shFFFF8000
`define DEC_MAX 2'h3
`define NUM_AIN 8
`define CHAN_SEL_W 4
`endif

/* rtl/analog_blocks_pkg.sv */
/*
  Types for the analog compare and scale blocks.
  Assumes the constants header is compiled alongside.
*/
package analog_blocks_pkg;
  typedef logic signed [15:0] word_t;
  typedef logic signed [31:0] wide_t;
  typedef logic [3:0] chan_sel_t;
endpackage

/* rtl/scale_if.sv */
/*
  Interface carrying one scaling request and its result.
  Assumes a combinational scaler on the far side.
*/
`timescale 1ns/100ps
interface scale_if;
  analog_blocks_pkg::word_t raw;
  analog_blocks_pkg::word_t gain;
  analog_blocks_pkg::word_t offset;
  analog_blocks_pkg::wide_t value;
  modport user (output raw, output gain, output offset, input value);
  modport calc (input raw, input gain, input offset, output value);
endinterface

/* rtl/analog_scaler.sv */
/*
  Scaler: raw times gain (hundredths) plus offset.
  Assumes inputs already limited to their legal ranges.
*/
`timescale 1ns/100ps
module analog_scaler (
  scale_if.calc s
);
  analog_blocks_pkg::wide_t prod;
  always_comb begin
    prod = 32'(s.raw) * 32'(s.gain);
    // Gain carries two fractional digits
    s.value = prod / 32'sd100 + 32'(s.offset);
  end
endmodule

/* rtl/analog_blocks.sv */
/*
  Comparator, threshold trigger, amplifier and value monitor, evaluated
  once per program cycle strobe. Assumes synchronous inputs on CLK_I.
*/
// Notes on behaviour
// - Actual value is raw times gain plus offset
// - Comparator uses scaled first minus scaled second
// - On>=Off: set above On, clear at/below Off
// - On<Off: comparator high when On<=diff<Off
// - Trigger hysteresis when On>=Off
// - Trigger window On<=value<Off when On<Off
// - Raw channel values are 0 to 1000
// - Gain within 10.00, offset within 10000
// - Thresholds and band within 20000
// - Decimals only for display, not compares
// - Thresholds fixed or from another block
// - Amplifier outputs scaled value, 16-bit signed
// - Arm rising edge captures reference value
// - Monitor flags value outside reference band
// - Comparator inputs from eight inputs or outputs
// - Monitor sets only while armed, outside band
// - Monitor clears inside band or when disarmed
`timescale 1ns/100ps
`include "analog_blocks_regs.svh"
module analog_blocks (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CYCLE_I,
  input wire logic [127:0] AIN_I,
  input wire logic [3:0] SEL_X_I,
  input wire logic [3:0] SEL_Y_I,
  input wire logic [15:0] GAIN_I,
  input wire logic [15:0] OFFSET_I,
  input wire logic [15:0] ON_PARAM_I,
  input wire logic [15:0] OFF_PARAM_I,
  input wire logic [15:0] ON_EXT_I,
  input wire logic [15:0] OFF_EXT_I,
  input wire logic ON_USE_EXT_I,
  input wire logic OFF_USE_EXT_I,
  input wire logic [15:0] DELTA_I,
  input wire logic [1:0] DECIMALS_I,
  input wire logic ARM_I,
  output logic CMP_O,
  output logic TRIG_O,
  output logic MON_O,
  output logic [15:0] SCALED_OUT_O,
  output logic [15:0] SCALED_OUT2_O,
  output logic [1:0] DECIMALS_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic analog_blocks_pkg::word_t lim(input logic [15:0] v,
                                                   input logic signed [15:0] m);
    analog_blocks_pkg::word_t x;
    x = $signed(v);
    if (x > m) begin
      lim = m;
    end else if (x < -m) begin
      lim = -m;
    end else begin
      lim = x;
    end
  endfunction

  function automatic analog_blocks_pkg::word_t sat(input analog_blocks_pkg::wide_t v);
    if (v > `OUT_MAX) begin
      sat = 16'sh7FFF;
    end else if (v < `OUT_MIN) begin
      sat = -16'sh8000;
    end else begin
      sat = v[15:0];
    end
  endfunction

  // Hysteresis or window decision shared by comparator and trigger
  function automatic logic decide(input analog_blocks_pkg::wide_t v,
                                  input analog_blocks_pkg::wide_t on_t,
                                  input analog_blocks_pkg::wide_t off_t,
                                  input logic prev);
    if (on_t >= off_t) begin
      decide = (v > on_t) ? 1'b1 : ((v <= off_t) ? 1'b0 : prev);
    end else begin
      decide = (on_t <= v) && (v < off_t);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Parameter limiting and selection
  analog_blocks_pkg::word_t gain, offset, on_t, off_t, delta;
  analog_blocks_pkg::word_t scaled_out_r, scaled_out2_r;
  analog_blocks_pkg::word_t raw_x, raw_y;
  logic [1:0] dec_r;

  always_comb begin
    gain = lim(GAIN_I, `GAIN_MAX);
    offset = lim(OFFSET_I, `OFFSET_MAX);
    on_t = lim(ON_USE_EXT_I ? ON_EXT_I : ON_PARAM_I, `THRESH_MAX);
    off_t = lim(OFF_USE_EXT_I ? OFF_EXT_I : OFF_PARAM_I, `THRESH_MAX);
    delta = lim(DELTA_I, `THRESH_MAX);
  end

  function automatic analog_blocks_pkg::word_t pick(input logic [3:0] sel,
                                                    input logic [127:0] ain,
                                                    input analog_blocks_pkg::word_t q1,
                                                    input analog_blocks_pkg::word_t q2);
    analog_blocks_pkg::word_t r;
    r = 16'sh0000;
    if (sel < 4'h8) begin
      r = $signed(ain[sel*16 +: 16]);
      if (r > `RAW_MAX) begin
        r = `RAW_MAX;
      end else if (r < 16'sh0000) begin
        r = 16'sh0000;
      end
    end else if (sel == 4'h8) begin
      r = q1;
    end else if (sel == 4'h9) begin
      r = q2;
    end
    pick = r;
  endfunction

  always_comb begin
    raw_x = pick(SEL_X_I, AIN_I, scaled_out_r, scaled_out2_r);
    raw_y = pick(SEL_Y_I, AIN_I, scaled_out_r, scaled_out2_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scaling
  scale_if sx ();
  scale_if sy ();
  assign sx.raw = raw_x;
  assign sx.gain = gain;
  assign sx.offset = offset;
  assign sy.raw = raw_y;
  assign sy.gain = gain;
  assign sy.offset = offset;
  analog_scaler u_sx (.s(sx));
  analog_scaler u_sy (.s(sy));

  analog_blocks_pkg::wide_t diff;
  assign diff = sx.value - sy.value;

  // Window membership of the difference, sampled by the checks
  logic in_win;
  assign in_win = (diff >= 32'(on_t)) && (diff < 32'(off_t));

  ////////////////////////////////////////////////////////////////////////////
  // Comparator and trigger
  logic cmp_r, trig_r;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cmp_r <= 1'b0;
    end else if (CYCLE_I) begin
      cmp_r <= decide(diff, 32'(on_t), 32'(off_t), cmp_r);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      trig_r <= 1'b0;
    end else if (CYCLE_I) begin
      trig_r <= decide(sx.value, 32'(on_t), 32'(off_t), trig_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Amplifier outputs
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scaled_out_r <= 16'sh0000;
      scaled_out2_r <= 16'sh0000;
      dec_r <= 2'h0;
    end else if (CYCLE_I) begin
      scaled_out_r <= sat(sx.value);
      scaled_out2_r <= sat(sy.value);
      dec_r <= DECIMALS_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Value monitor
  logic arm_prev_r, mon_r;
  analog_blocks_pkg::wide_t ref_r;
  logic outside;
  always_comb begin
    outside = (sx.value > ref_r + 32'(delta)) || (sx.value < ref_r - 32'(delta));
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      arm_prev_r <= 1'b0;
      ref_r <= 32'sh00000000;
    end else if (CYCLE_I) begin
      arm_prev_r <= ARM_I;
      if (ARM_I && !arm_prev_r) begin
        ref_r <= sx.value;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mon_r <= 1'b0;
    end else if (CYCLE_I) begin
      if (!ARM_I || (ARM_I && !arm_prev_r)) begin
        mon_r <= 1'b0;
      end else begin
        mon_r <= outside;
      end
    end
  end

  assign CMP_O = cmp_r;
  assign TRIG_O = trig_r;
  assign MON_O = mon_r;
  assign SCALED_OUT_O = scaled_out_r;
  assign SCALED_OUT2_O = scaled_out2_r;
  assign DECIMALS_O = dec_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_hold;
    @(posedge CLK_I) disable iff (RST_I)
      !CYCLE_I |=> $stable(CMP_O) && $stable(TRIG_O) && $stable(MON_O);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved off cycle");
  property p_cmp_set;
    @(posedge CLK_I) disable iff (RST_I)
      CYCLE_I && on_t >= off_t && diff > 32'(on_t) |=> CMP_O;
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("comparator not set");
  property p_cmp_clr;
    @(posedge CLK_I) disable iff (RST_I)
      CYCLE_I && on_t >= off_t && diff <= 32'(off_t) |=> !CMP_O;
  endproperty
  a_cmp_clr: assert property (p_cmp_clr) else $error("comparator not cleared");
  property p_cmp_win;
    @(posedge CLK_I) disable iff (RST_I)
      CYCLE_I && on_t < off_t |=> CMP_O == $past(in_win);
  endproperty
  a_cmp_win: assert property (p_cmp_win) else $error("comparator window");
  property p_trig_clr;
    @(posedge CLK_I) disable iff (RST_I)
      CYCLE_I && on_t >= off_t && sx.value <= 32'(off_t) |=> !TRIG_O;
  endproperty
  a_trig_clr: assert property (p_trig_clr) else $error("trigger not cleared");
  property p_trig_win;
    @(posedge CLK_I) disable iff (RST_I)
      CYCLE_I && on_t < off_t && sx.value < 32'(on_t) |=> !TRIG_O;
  endproperty
  a_trig_win: assert property (p_trig_win) else $error("trigger window");
  property p_sat;
    @(posedge CLK_I) disable iff (RST_I)
      CYCLE_I && sx.value > `OUT_MAX |=> SCALED_OUT_O == 16'h7FFF;
  endproperty
  a_sat: assert property (p_sat) else $error("no saturation");
  property p_mon_arm;
    @(posedge CLK_I) disable iff (RST_I)
      CYCLE_I && !ARM_I |=> !MON_O;
  endproperty
  a_mon_arm: assert property (p_mon_arm) else $error("monitor set while disarmed");
  property p_mon_in;
    @(posedge CLK_I) disable iff (RST_I)
      CYCLE_I && !outside |=> !MON_O;
  endproperty
  a_mon_in: assert property (p_mon_in) else $error("monitor set inside band");
  property p_mon_set;
    @(posedge CLK_I) disable iff (RST_I)
      CYCLE_I && ARM_I && arm_prev_r && outside |=> MON_O;
  endproperty
  a_mon_set: assert property (p_mon_set) else $error("monitor not set outside band");
  property p_ref;
    @(posedge CLK_I) disable iff (RST_I)
      CYCLE_I && ARM_I && !arm_prev_r |=> ref_r == $past(sx.value);
  endproperty
  a_ref: assert property (p_ref) else $error("reference not captured");
  c_cmp: cover property (@(posedge CLK_I) $rose(CMP_O));
  c_trig: cover property (@(posedge CLK_I) $rose(TRIG_O));
  c_mon: cover property (@(posedge CLK_I) $rose(MON_O));
endmodule

/* testbench/ain_source.sv */
/*
  Model of the analog input channels feeding the blocks.
  Assumes the bench sets each channel between clock edges.
*/
`timescale 1ns/100ps
module ain_source (
  output logic [127:0] AIN_O
);
  logic [15:0] chan_r [8];
  initial for (int i = 0; i < 8; i++) chan_r[i] = 16'h0000;
  task automatic set_chan(input int ch, input int v);
    chan_r[ch] = 16'(v);
  endtask
  always_comb for (int i = 0; i < 8; i++) AIN_O[16*i +: 16] = chan_r[i];
endmodule

/* testbench/testbench.sv */
/*
  Self-checking bench for analog_blocks with a reference model.
  Assumes one evaluation per CLK_I edge with CYCLE_I high, outputs one cycle later.
*/
`timescale 1ns/100ps
module testbench;
  typedef struct {logic c, t, m; logic [15:0] sx, sy; logic [1:0] d;} exp_s;
  logic CLK_I = 0, RST_I = 1, CYCLE_I = 0, ARM_I = 0, ON_USE_EXT_I = 0, OFF_USE_EXT_I = 0;
  logic [3:0] SEL_X_I = 0, SEL_Y_I = 0;
  logic [15:0] GAIN_I = 0, OFFSET_I = 0, ON_PARAM_I = 0, OFF_PARAM_I = 0, DELTA_I = 0;
  logic [15:0] ON_EXT_I = 0, OFF_EXT_I = 0, SCALED_OUT_O, SCALED_OUT2_O, qx = 0, qy = 0;
  logic [1:0] DECIMALS_I = 0, DECIMALS_O;
  logic [127:0] ain;
  logic CMP_O, TRIG_O, MON_O, c_m = 0, t_m = 0, m_m = 0, arm_m = 0;
  exp_s q[$];
  exp_s last = '{0, 0, 0, 0, 0, 0};
  int mismatches = 0, n_checks = 0, cycles = 0, raw[8], sx, sy, ref_v = 0;
  always #5 CLK_I = ~CLK_I;
  ain_source i_src (.AIN_O(ain));
  analog_blocks i_dut (.CLK_I(CLK_I), .RST_I(RST_I), .CYCLE_I(CYCLE_I), .AIN_I(ain),
    .SEL_X_I(SEL_X_I), .SEL_Y_I(SEL_Y_I), .GAIN_I(GAIN_I), .OFFSET_I(OFFSET_I),
    .ON_PARAM_I(ON_PARAM_I), .OFF_PARAM_I(OFF_PARAM_I), .ON_EXT_I(ON_EXT_I),
    .OFF_EXT_I(OFF_EXT_I), .ON_USE_EXT_I(ON_USE_EXT_I), .OFF_USE_EXT_I(OFF_USE_EXT_I),
    .DELTA_I(DELTA_I), .DECIMALS_I(DECIMALS_I), .ARM_I(ARM_I), .CMP_O(CMP_O),
    .TRIG_O(TRIG_O), .MON_O(MON_O), .SCALED_OUT_O(SCALED_OUT_O),
    .SCALED_OUT2_O(SCALED_OUT2_O), .DECIMALS_O(DECIMALS_O));
  ////////////////////////////////////////////////////////////////////////////
  function automatic int lim(int v, int m);
    return v > m ? m : v < -m ? -m : v;
  endfunction
  function automatic int scl(int r);
    return r * lim($signed(GAIN_I), 1000) / 100 + lim($signed(OFFSET_I), 10000);
  endfunction
  function automatic logic [15:0] sat(int v);
    return v > 32767 ? 16'h7FFF : v < -32768 ? 16'h8000 : 16'(v);
  endfunction
  function automatic int src(logic [3:0] s);
    if (s < 8) return raw[s[2:0]] < 0 ? 0 : raw[s[2:0]] > 1000 ? 1000 : raw[s[2:0]];
    return s == 8 ? int'($signed(qx)) : s == 9 ? int'($signed(qy)) : 0;
  endfunction
  function automatic logic hyst(int v, int on, int off, logic prev);
    if (on >= off) return v > on ? 1'b1 : v <= off ? 1'b0 : prev;
    return v >= on && v < off;
  endfunction
  task automatic model();
    int on, off, d;
    on = lim(ON_USE_EXT_I ? $signed(ON_EXT_I) : $signed(ON_PARAM_I), 20000);
    off = lim(OFF_USE_EXT_I ? $signed(OFF_EXT_I) : $signed(OFF_PARAM_I), 20000);
    d = lim($signed(DELTA_I), 20000);
    sx = scl(src(SEL_X_I));
    sy = scl(src(SEL_Y_I));
    c_m = hyst(sx - sy, on, off, c_m);
    t_m = hyst(sx, on, off, t_m);
    if (ARM_I && !arm_m) begin
      ref_v = sx;
      m_m = 0;
    end else m_m = ARM_I && (sx > ref_v + d || sx < ref_v - d);
    arm_m = ARM_I;
    qx = sat(sx);
    qy = sat(sy);
    q.push_back('{c_m, t_m, m_m, qx, qy, DECIMALS_I});
  endtask
  task automatic step(bit cyc);
    int e, v;
    @(posedge CLK_I);
    #1;
    for (int i = 0; i < 8; i++) begin
      raw[i] = int'($urandom_range(1100)) - 50;
      i_src.set_chan(i, raw[i]);
    end
    SEL_X_I = 4'($urandom_range(15));
    SEL_Y_I = 4'($urandom_range(15));
    GAIN_I = $urandom_range(1) ? 16'h0064 : 16'($urandom_range(2400) - 1200);
    OFFSET_I = 16'($urandom_range(7) ? $urandom_range(2000) - 1000 : $urandom_range(24000) - 12000);
    {ON_USE_EXT_I, OFF_USE_EXT_I, ARM_I} = 3'($urandom);
    ON_PARAM_I = 16'($urandom_range(2000) - 1000);
    OFF_PARAM_I = 16'($urandom_range(2000) - 1000);
    ON_EXT_I = 16'($urandom_range(2000) - 1000);
    OFF_EXT_I = 16'($urandom_range(50000) - 25000);
    DELTA_I = 16'($urandom_range(120) - 20);
    v = scl(src(SEL_X_I));
    e = v - scl(src(SEL_Y_I)) + int'($urandom_range(2)) - 1;
    if ($urandom_range(2) == 0 && e < 20000 && e > -20000) {ON_PARAM_I, ON_EXT_I} = {2{16'(e)}};
    if ($urandom_range(2) == 0 && v < 20000 && v > -20000) {OFF_PARAM_I, OFF_EXT_I} = {2{16'(v)}};
    CYCLE_I = cyc;
    if (cyc) begin
      DECIMALS_I = 2'($urandom);
      model();
    end
  endtask
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Output watcher: takes the oldest expectation on each evaluation edge
  always @(posedge CLK_I) begin
    if (RST_I === 1'b0) begin
      if (CYCLE_I === 1'b1 && q.size() > 0) last = q.pop_front();
      #2;
      check("cmp", {15'h0000, CMP_O}, {15'h0000, last.c});
      check("trig", {15'h0000, TRIG_O}, {15'h0000, last.t});
      check("mon", {15'h0000, MON_O}, {15'h0000, last.m});
      check("scaled_x", SCALED_OUT_O, last.sx);
      check("scaled_y", SCALED_OUT2_O, last.sy);
      check("decimals", {14'h0000, DECIMALS_O}, {14'h0000, last.d});
    end
  end
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'hC1DA));
    repeat (12) @(posedge CLK_I);
    #1 RST_I = 0;
    repeat (500) step($urandom_range(3) != 0);
    step(0);
    #1 RST_I = 1;
    {c_m, t_m, m_m, arm_m, qx, qy, DECIMALS_I} = '0;
    last = '{0, 0, 0, 0, 0, 0};
    q.delete();
    #3;
    check("reset", {CMP_O, TRIG_O, MON_O, DECIMALS_O}, 16'h0000);
    check("reset_q", SCALED_OUT_O | SCALED_OUT2_O, 16'h0000);
    @(posedge CLK_I);
    #1 RST_I = 0;
    repeat (300) step($urandom_range(3) != 0);
    step(0);
    repeat (2) @(posedge CLK_I);
    #3 test_done();
  end
endmodule
